/* File: rtl/esram_pkg.sv */
// shared constants and carriers for the embedded sram block
package esram_pkg;
	// array shape: 512 words of 9 bits hold the 4,608 bits of one block
	localparam int DATA_W    = 9;
	localparam int ADDR_W    = 9;
	localparam int DEPTH     = 512;
	localparam int INIT_BITS = 4608;

	// serial load counters
	localparam int BIT_CNT_W = 4;
	localparam int TOT_CNT_W = 13;
	localparam logic [BIT_CNT_W-1:0] BIT_LAST  = 4'h8;
	localparam logic [ADDR_W-1:0]    WORD_LAST = 9'h1FF;
	localparam logic [TOT_CNT_W-1:0] TOT_BITS  = 13'h1200;

	// reset values
	localparam logic [DATA_W-1:0]    DATA_RST  = 9'h000;
	localparam logic [ADDR_W-1:0]    ADDR_RST  = 9'h000;
	localparam logic [BIT_CNT_W-1:0] BIT_RST   = 4'h0;
	localparam logic [TOT_CNT_W-1:0] TOT_RST   = 13'h0000;

	// synchroniser lane positions for the scan pins
	localparam int SYNC_W   = 3;
	localparam int SY_SEL   = 0;
	localparam int SY_CLK   = 1;
	localparam int SY_DIN   = 2;
	localparam logic [SYNC_W-1:0] SYNC_RST = 3'h0;

	// write port bundle
	typedef struct packed {
		logic              en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} esram_wr_t;

	// read port bundle
	typedef struct packed {
		logic              en;
		logic [ADDR_W-1:0] addr;
	} esram_rd_t;

	// serial load pins from the user scan access
	typedef struct packed {
		logic sel;
		logic sclk;
		logic sdi;
	} esram_scan_t;
endpackage : esram_pkg

/* File: rtl/esram_block.sv */
`timescale 1ns/1ns
`default_nettype none
module esram_block
	import esram_pkg::*;
(
	input  wire logic                mclk,         // single system clock, 125 MHz
	input  wire logic                rst,          // async, active high
	input  wire logic                out_reg_en,   // output-register option, held static in use
	input  wire esram_rd_t           rd,           // read request
	input  wire esram_wr_t           wr,           // write request
	input  wire esram_scan_t         scan,         // serial load pins, asynchronous
	output logic [DATA_W-1:0]        rd_data,      // read word, from a flop
	output logic                     rd_valid,     // one-cycle pulse with rd_data
	output logic                     init_busy,    // serial load selected
	output logic                     init_done     // full block loaded
);

	// storage array, no reset: contents survive until rewritten
	logic [DATA_W-1:0] mem [DEPTH];

	// scan pin synchroniser stages
	logic [SYNC_W-1:0] sync1_r;            // first stage, read only by sync2_r
	logic [SYNC_W-1:0] sync2_r;            // settled pin levels
	logic              sclk_prev_r;        // previous settled scan clock

	// read pipeline state
	logic [DATA_W-1:0] stage_r, stage_nxt; // pipelined capture
	logic              stage_v_r, stage_v_nxt;
	logic [DATA_W-1:0] rd_data_r, rd_data_nxt;
	logic              rd_valid_r, rd_valid_nxt;

	// serial load state
	logic [DATA_W-1:0]    shift_r, shift_nxt;     // word being assembled
	logic [BIT_CNT_W-1:0] bit_r, bit_nxt;         // bit position in word
	logic [ADDR_W-1:0]    iaddr_r, iaddr_nxt;     // word being loaded
	logic [TOT_CNT_W-1:0] tot_r, tot_nxt;         // bits taken this operation
	logic                 done_r, done_nxt;

	// decoded strobes
	logic              sclk_rise;          // scan bit arrives
	logic              init_go;            // a full loaded word is written
	logic              wr_go;              // user write is taken
	logic [DATA_W-1:0] init_word;          // word with the final bit shifted in
	logic [DATA_W-1:0] rd_word;            // array word at read address
	logic [DATA_W-1:0] wr_old;             // array word at write address

	// two-flop capture of the asynchronous scan pins
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sync1_r     <= SYNC_RST;
			sync2_r     <= SYNC_RST;
			sclk_prev_r <= 1'b0;
		end else begin
			sync1_r     <= {scan.sdi, scan.sclk, scan.sel};
			sync2_r     <= sync1_r;
			sclk_prev_r <= sync2_r[SY_CLK];
		end
	end

	// edge seen only after settling; a fast scan clock would drop bits, so it must stay well below mclk/4
	assign sclk_rise = sync2_r[SY_CLK] & ~sclk_prev_r & sync2_r[SY_SEL];
	assign init_word = {shift_r[DATA_W-2:0], sync2_r[SY_DIN]};
	assign init_go   = sclk_rise && (bit_r == BIT_LAST) && !done_r;
	// user writes are held off while a load owns the array
	assign wr_go     = wr.en && !sync2_r[SY_SEL];
	assign rd_word   = mem[rd.addr];
	assign wr_old    = mem[wr.addr];

	// serial load next-state
	always_comb begin
		shift_nxt = shift_r;
		bit_nxt   = bit_r;
		iaddr_nxt = iaddr_r;
		tot_nxt   = tot_r;
		done_nxt  = done_r;
		if (!sync2_r[SY_SEL]) begin
			// deselect ends the operation; done is kept for software to see
			bit_nxt   = BIT_RST;
			iaddr_nxt = ADDR_RST;
			tot_nxt   = TOT_RST;
		end else if (sclk_rise && !done_r) begin
			// count every bit of the block
			shift_nxt = init_word;
			tot_nxt   = tot_r + 13'h0001;
			if (bit_r == BIT_LAST) begin
				bit_nxt   = BIT_RST;
				iaddr_nxt = iaddr_r + 9'h001;
				if (iaddr_r == WORD_LAST) begin
					done_nxt = 1'b1;
				end
			end else begin
				bit_nxt = bit_r + 4'h1;
			end
		end
		// a fresh selection restarts a finished load
		if (sync2_r[SY_SEL] && done_r && tot_r == TOT_RST) begin
			done_nxt = 1'b0;
		end
	end

	// serial load registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			shift_r <= DATA_RST;
			bit_r   <= BIT_RST;
			iaddr_r <= ADDR_RST;
			tot_r   <= TOT_RST;
			done_r  <= 1'b0;
		end else begin
			shift_r <= shift_nxt;
			bit_r   <= bit_nxt;
			iaddr_r <= iaddr_nxt;
			tot_r   <= tot_nxt;
			done_r  <= done_nxt;
		end
	end

	// array writes: load word or user word, never both in one cycle
	always_ff @(posedge mclk) begin
		if (init_go) begin
			mem[iaddr_r] <= init_word;
		end else if (wr_go) begin
			mem[wr.addr] <= wr.data;
		end
	end

	// read path next-state; read-before-write on a shared address
	always_comb begin
		stage_nxt    = stage_r;
		stage_v_nxt  = 1'b0;
		rd_data_nxt  = rd_data_r;
		rd_valid_nxt = 1'b0;
		if (out_reg_en) begin
			if (rd.en) begin
				stage_nxt = rd_word;
			end
			stage_v_nxt = rd.en;
			if (stage_v_r) begin
				rd_data_nxt  = stage_r;
				rd_valid_nxt = 1'b1;
			end
		end else if (rd.en) begin
			rd_data_nxt  = rd_word;
			rd_valid_nxt = 1'b1;
		end
	end

	// read path registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stage_r    <= DATA_RST;
			stage_v_r  <= 1'b0;
			rd_data_r  <= DATA_RST;
			rd_valid_r <= 1'b0;
		end else begin
			stage_r    <= stage_nxt;
			stage_v_r  <= stage_v_nxt;
			rd_data_r  <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
		end
	end

	assign rd_data   = rd_data_r;
	assign rd_valid  = rd_valid_r;
	assign init_busy = sync2_r[SY_SEL];
	assign init_done = done_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_np_read_valid: assert property (rd.en && !out_reg_en |=> rd_valid)
		else $error("non-pipelined read gave no valid");
	a_np_read_data: assert property (rd.en && !out_reg_en |=> rd_data == $past(rd_word))
		else $error("non-pipelined read data wrong");
	a_pl_read_data: assert property (rd.en && out_reg_en ##1 out_reg_en |=>
		rd_valid && rd_data == $past(rd_word, 2))
		else $error("pipelined read data wrong or late");
	a_pl_no_early: assert property (out_reg_en && !stage_v_r |=> !rd_valid)
		else $error("pipelined read presented data too early");
	a_wr_store: assert property (wr_go && !init_go |=> mem[$past(wr.addr)] == $past(wr.data))
		else $error("written word not stored");
	// idle keeps word
	// case equality: words never written yet must also count as unchanged
	a_wr_hold: assert property (!wr_go && !init_go |=> mem[$past(wr.addr)] === $past(wr_old))
		else $error("word changed without a strobe");
	a_init_select: assert property (init_go |-> sync2_r[SY_SEL] && init_busy)
		else $error("load wrote while not selected");
	a_init_count: assert property ($rose(done_r) |-> tot_r == TOT_BITS)
		else $error("load finished at wrong bit count");
	a_init_store: assert property (init_go |=> mem[$past(iaddr_r)] == $past(init_word))
		else $error("loaded word not stored");

	c_np_read: cover property (rd.en && !out_reg_en ##1 rd_valid);
	c_pl_read: cover property (rd.en && out_reg_en ##2 rd_valid);
	c_write: cover property (wr_go ##1 rd.en && rd.addr == $past(wr.addr));
	c_init_done: cover property ($rose(done_r));
	c_reselect: cover property ($fell(done_r));

endmodule : esram_block
`default_nettype wire

/* File: bench/esram_loader.sv */
`timescale 1ns/1ns
`default_nettype none
// stands in for the external scan loader feeding the serial load pins
module esram_loader
	import esram_pkg::*;
(
	input  wire logic         mclk,   // system clock
	input  wire logic         go,     // start a load; a second rise gives a short reselect
	output var  esram_scan_t  scan    // scan pins toward the block
);
	int          i;               // bit index over the whole block
	logic [8:0]  w;               // word being shifted
	logic        sel_r  = 1'b0;   // select level
	logic        sclk_r = 1'b0;   // scan clock, stands still low outside the frame
	logic        sdi_r  = 1'b0;   // data bit during a frame
	logic        idle_r = 1'b0;   // level of the floating data pin while unselected
	// unselected data pin is not held: it toggles so no stale bit looks valid
	always @(posedge mclk) idle_r <= ~idle_r;
	// one driver for the whole pin bundle
	always_comb scan = '{sel: sel_r, sclk: sclk_r, sdi: sel_r ? sdi_r : idle_r};
	initial begin
		wait (go);
		@(posedge mclk);
		sel_r <= 1'b1;
		repeat (4) @(posedge mclk);
		// select, then shift every word msb first
		for (i = 0; i < INIT_BITS; i++) begin
			w = 9'(i / 9) ^ 9'h0A5;
			sdi_r <= w[8 - i % 9];
			repeat (3) @(posedge mclk);
			sclk_r <= 1'b1;
			repeat (3) @(posedge mclk);
			sclk_r <= 1'b0;
		end
		repeat (8) @(posedge mclk);
		sel_r <= 1'b0;
		// short second selection with no bits: only restarts the done flag
		wait (!go);
		wait (go);
		@(posedge mclk);
		sel_r <= 1'b1;
		repeat (40) @(posedge mclk);
		sel_r <= 1'b0;
	end
endmodule : esram_loader
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top
	import esram_pkg::*;
;
	logic              mclk = 1'b0, rst = 1'b1, out_reg_en = 1'b0, go = 1'b0;
	esram_rd_t         rd = '0;                 // read request
	esram_wr_t         wr = '0;                 // write request
	esram_scan_t       scan;                    // from the loader
	logic [DATA_W-1:0] rd_data, shadow [DEPTH]; // result and reference array
	logic              rd_valid, init_busy, init_done;
	logic [1:0]        en_sh = '0;              // taken read strobes, newest in bit 0
	logic [DATA_W-1:0] exp_w;                   // oldest expected word, popped once
	bit                hold_wr = 1'b0;          // writes issued while they must be refused
	logic [DATA_W-1:0] exp_q [$];               // expected words in issue order
	int                num_errors = 0, tests_run = 0, seed = 32'h37428aa1, k;
	always #4 mclk = ~mclk;
	esram_block uut (.mclk(mclk), .rst(rst), .out_reg_en(out_reg_en), .rd(rd), .wr(wr), .scan(scan),
		.rd_data(rd_data), .rd_valid(rd_valid), .init_busy(init_busy), .init_done(init_done));
	esram_loader ldr (.mclk(mclk), .go(go), .scan(scan));
	// remember which edges took a read
	always @(posedge mclk) en_sh <= {en_sh[0], rd.en};
	// result watcher, samples where outputs have settled
	always @(negedge mclk) if (!rst) begin
		// latency picked by the option: valid right after the taking edge, or one edge later
		`CHK(rd_valid, out_reg_en ? en_sh[1] : en_sh[0])
		if (rd_valid === 1'b1) begin
			// pop once; an empty queue leaves an unknown that can never match
			exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
			`CHK(rd_data, exp_w)
		end
	end
	// one cycle of traffic; the read sees the array before this edge's write
	task automatic op(input bit re, input bit we, input logic [ADDR_W-1:0] ra);
		logic [ADDR_W-1:0] wa;
		logic [DATA_W-1:0] wd;
		wa = ADDR_W'($random(seed)) | 9'h1F8;
		wd = DATA_W'($random(seed));
		@(posedge mclk);
		rd <= '{re, ra};
		wr <= '{we, wa, wd};
		if (re) exp_q.push_back(shadow[ra]);
		// a refused write leaves the reference untouched
		if (we && !hold_wr) shadow[wa] = wd;
	endtask : op
	// random mix on the top eight words, so reads hit fresh writes
	task automatic burst(input int n);
		repeat (n) op(1'($random(seed)), 1'($random(seed)), ADDR_W'($random(seed)) | 9'h1F8);
		@(posedge mclk);
		rd <= '0;
		wr <= '0;
		repeat (4) @(posedge mclk);
	endtask : burst
	task automatic wrap_up;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	// load takes about 28k cycles; leave ample margin
	initial begin
		repeat (60000) @(posedge mclk);
		num_errors++;
		wrap_up();
	end
	initial begin
		for (k = 0; k < DEPTH; k++) shadow[k] = DATA_W'(k) ^ 9'h0A5;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		go <= 1'b1;
		for (k = 0; k < 40000 && init_done !== 1'b1; k++) @(posedge mclk);
		`CHK(init_done, 1'b1)
		for (k = 0; k < 60 && init_busy !== 1'b0; k++) @(posedge mclk);
		// sweep every word back to back, write strobe low
		for (k = 0; k < DEPTH; k++) op(1'b1, 1'b0, ADDR_W'(k));
		burst(300);
		out_reg_en <= 1'b1;
		repeat (2) @(posedge mclk);
		burst(300);
		// a second selection clears done; user writes meanwhile are refused
		go <= 1'b0;
		@(posedge mclk);
		go <= 1'b1;
		for (k = 0; k < 20 && init_busy !== 1'b1; k++) @(posedge mclk);
		`CHK(init_busy, 1'b1)
		@(posedge mclk);
		`CHK(init_done, 1'b0)
		hold_wr = 1'b1;
		repeat (8) op(1'b0, 1'b1, ADDR_RST);
		burst(0);
		hold_wr = 1'b0;
		for (k = 0; k < 60 && init_busy !== 1'b0; k++) @(posedge mclk);
		// top words still hold what was written before the selection
		for (k = 0; k < 8; k++) op(1'b1, 1'b0, ADDR_W'(k) | 9'h1F8);
		burst(0);
		// every issued read produced exactly one result
		`CHK(exp_q.size(), 0)
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
